// ==== rtl/sdpc_burst_addr.sv ====
// Burst column generator: column for beat cnt and a last-beat flag.
// Assumes cnt starts at zero and rises by one per running edge.
module sdpc_burst_addr
  import sdpc_pkg::*;
(
  // Burst description
  input  wire logic [COL_W-1:0]    start,
  input  wire logic [COL_W-1:0]    cnt,
  input  wire logic [CFG_BL_W-1:0] bl,
  input  wire logic                interleave,
  // Result
  output logic      [COL_W-1:0]    col,
  output logic                     last
);
  logic [COL_W-1:0] msk;

  // Wrap inside the aligned block; a full page wraps on the whole row and never ends
  always_comb begin
    msk  = (bl == BL_PAGE) ? '1 : COL_W'((1 << bl) - 1);
    last = (bl != BL_PAGE) && (cnt == msk);
    if (interleave && (bl != BL_PAGE)) begin
      col = (start & ~msk) | ((start ^ cnt) & msk);
    end else begin
      col = (start & ~msk) | (COL_W'(start + cnt) & msk);
    end
  end
endmodule // sdpc_burst_addr

// ==== rtl/sdpc_cmd_dec.sv ====
// Command decoder: turns the decoder enable and three strobes into a command.
// Assumes the caller qualifies the result with its own power state.
module sdpc_cmd_dec
  import sdpc_pkg::*;
(
  // Strobes
  input  wire logic      cs_n,
  input  wire logic      ras_n,
  input  wire logic      cas_n,
  input  wire logic      we_n,
  // Decoded command
  output sdpc_cmd_t      cmd
);
  // Decoder enable high masks every strobe combination
  always_comb begin
    cmd = SDPC_INHIBIT;
    if (!cs_n) begin
      case ({ras_n, cas_n, we_n})
        STB_LOADCFG: cmd = SDPC_LOADCFG;
        STB_REFRESH: cmd = SDPC_REFRESH;
        STB_PRECH:   cmd = SDPC_PRECH;
        STB_ACTIVE:  cmd = SDPC_ACTIVE;
        STB_WRITE:   cmd = SDPC_WRITE;
        STB_READ:    cmd = SDPC_READ;
        STB_TERM:    cmd = SDPC_TERM;
        default:     cmd = SDPC_NOP;
      endcase
    end
  end
endmodule // sdpc_cmd_dec

// ==== rtl/sdpc_pin_cmd.sv ====
// Device side of the DRAM pin command interface with a small flop array.
// Assumes one clock, pins synchronous to pclk, registers reached over APB.
//
// The APB interface to the registers and the register offsets were left to the implementer.
module sdpc_pin_cmd
  import sdpc_pkg::*;
(
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [PDATA_W-1:0] pwdata,
  output logic      [PDATA_W-1:0] prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Command pins
  input  wire logic               cke,
  input  wire logic               cs_n,
  input  wire logic               ras_n,
  input  wire logic               cas_n,
  input  wire logic               we_n,
  input  wire logic               dqm,
  input  wire logic [BANK_W-1:0]  bank_select,
  input  wire logic [ADDR_W-1:0]  address_lines,
  // Data pins, split three ways
  input  wire logic [DATA_W-1:0]  data_lines_i,
  output logic      [DATA_W-1:0]  data_lines_o,
  output logic                    data_lines_oe_n
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    sdpc_pwr_t                          pwr;
    logic [CFG_W-1:0]                   cfg;
    logic [BANKS-1:0]                   open;
    logic [BANKS-1:0][ADDR_W-1:0]       row;
    logic                               bact;
    logic                               bwr;
    logic                               bap;
    logic [BANK_W-1:0]                  bbank;
    logic [COL_W-1:0]                   bstart;
    logic [COL_W-1:0]                   bcnt;
    logic [MEM_DEPTH-1:0][DATA_W-1:0]   mem;
    logic                               rvalid;
    logic [DATA_W-1:0]                  rdata;
    logic                               dqm;
    logic [DATA_W-1:0]                  dout;
    logic                               doe_n;
    logic [PDATA_W-1:0]                 prdata;
    logic                               pready;
    logic                               pslverr;
  } sdpc_state_t;

  sdpc_state_t                    st_q;
  sdpc_state_t                    st_d;
  sdpc_cmd_t                      cmd;
  logic                           live;
  logic                           new_burst;
  logic                           go;
  logic [COL_W-1:0]               start_m;
  logic [COL_W-1:0]               cnt_m;
  logic [BANK_W-1:0]              bank_m;
  logic                           wr_m;
  logic                           ap_m;
  logic [COL_W-1:0]               col;
  logic                           last;
  logic [BANK_W+MEM_IDX_W-1:0]    idx;
  logic [PDATA_W-1:0]             stat;

  // ---------------------------------------------------------------
  // Decode and burst address
  // ---------------------------------------------------------------
  sdpc_cmd_dec sdpc_cmd_dec_inst (
    .cs_n  (cs_n),
    .ras_n (ras_n),
    .cas_n (cas_n),
    .we_n  (we_n),
    .cmd   (cmd)
  );

  // A new read or write replaces any burst in flight at the same edge
  assign live      = cke && ((st_q.pwr == PWR_RUN) || (st_q.pwr == PWR_SUSPEND));
  assign new_burst = (cmd == SDPC_READ) || (cmd == SDPC_WRITE);
  assign go        = new_burst || st_q.bact;
  assign start_m   = new_burst ? address_lines[COL_W-1:0] : st_q.bstart;
  assign cnt_m     = new_burst ? '0 : st_q.bcnt;
  assign bank_m    = new_burst ? bank_select : st_q.bbank;
  assign wr_m      = new_burst ? (cmd == SDPC_WRITE) : st_q.bwr;
  assign ap_m      = new_burst ? address_lines[PRE_SCOPE_BIT] : st_q.bap;
  assign idx       = {bank_m, col[MEM_IDX_W-1:0]};

  sdpc_burst_addr sdpc_burst_addr_inst (
    .start      (start_m),
    .cnt        (cnt_m),
    .bl         (st_q.cfg[CFG_BL_LSB +: CFG_BL_W]),
    .interleave (st_q.cfg[CFG_ORDER_BIT]),
    .col        (col),
    .last       (last)
  );

  // ---------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------
  always_comb begin
    stat = '0;
    stat[STAT_PWR_LSB +: $bits(sdpc_pwr_t)] = st_q.pwr;
    stat[STAT_OPEN_LSB +: BANKS]            = st_q.open;
    stat[STAT_RD_BIT]                       = st_q.bact && !st_q.bwr;
    stat[STAT_WR_BIT]                       = st_q.bact && st_q.bwr;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // APB: answer registered in setup, write lands at the access edge
    st_d.pready = psel && !penable;
    if (psel && !penable) begin
      st_d.pslverr = 1'b0;
      st_d.prdata  = '0;
      if (paddr == REG_CFG) begin
        st_d.prdata = PDATA_W'(st_q.cfg);
      end else if (paddr == REG_STAT) begin
        st_d.prdata = stat;
      end else begin
        st_d.pslverr = 1'b1;
      end
    end
    if (psel && penable && st_q.pready && pwrite && (paddr == REG_CFG)) begin
      st_d.cfg = pwdata[CFG_W-1:0];
    end

    case (st_q.pwr)
      PWR_RUN, PWR_SUSPEND: begin
        if (!cke) begin
          // Internal clock stops; what it stops into depends on bank state
          if (st_q.bact) begin
            st_d.pwr = PWR_SUSPEND;
          end else if (st_q.open == '0) begin
            st_d.pwr = (cmd == SDPC_REFRESH) ? PWR_SELF : PWR_PD_PRE;
          end else begin
            st_d.pwr = PWR_PD_ACT;
          end
          if (!st_q.bact) begin
            st_d.doe_n  = 1'b1;
            st_d.rvalid = 1'b0;
          end
        end else begin
          st_d.pwr = PWR_RUN;
          // Output registers: byte mask is one flop deep here, so two edges to the pins
          st_d.dqm    = dqm;
          st_d.dout   = st_q.rdata;
          st_d.doe_n  = !(st_q.rvalid && !st_q.dqm);
          st_d.rvalid = 1'b0;
          // Burst beat; runs regardless of the decoder enable
          if (go) begin
            if (wr_m) begin
              if (!dqm) begin
                st_d.mem[idx] = data_lines_i;
              end
            end else begin
              st_d.rvalid = 1'b1;
              st_d.rdata  = st_q.mem[idx];
            end
            st_d.bstart = start_m;
            st_d.bwr    = wr_m;
            st_d.bbank  = bank_m;
            st_d.bap    = ap_m;
            if (last) begin
              st_d.bact = 1'b0;
              st_d.bcnt = '0;
              if (ap_m) begin
                st_d.open[bank_m] = 1'b0;
              end
            end else begin
              st_d.bact = 1'b1;
              st_d.bcnt = COL_W'(cnt_m + 1'b1);
            end
          end
          // Commands; an inhibited decoder falls through to default
          case (cmd)
            SDPC_ACTIVE: begin
              st_d.open[bank_select] = 1'b1;
              st_d.row[bank_select]  = address_lines;
            end
            SDPC_PRECH: begin
              if (address_lines[PRE_SCOPE_BIT]) begin
                st_d.open = '0;
              end else begin
                st_d.open[bank_select] = 1'b0;
              end
              if (!st_d.open[st_d.bbank]) begin
                st_d.bact = 1'b0;
              end
            end
            SDPC_TERM: begin
              st_d.bact = 1'b0;
            end
            SDPC_LOADCFG: begin
              st_d.cfg = {bank_select, address_lines};
            end
            default: begin
            end
          endcase
        end
      end
      default: begin
        // Receivers off: only the clock gate is watched, exit beat is a no-op
        if (cke) begin
          st_d.pwr = PWR_RUN;
        end
      end
    endcase
  end

  // Register everything at the rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q       <= '0;
      st_q.cfg   <= CFG_RST;
      st_q.doe_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata          = st_q.prdata;
  assign pready          = st_q.pready;
  assign pslverr         = st_q.pslverr;
  assign data_lines_o    = st_q.dout;
  assign data_lines_oe_n = st_q.doe_n;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence read_issue;
    live && (cmd == SDPC_READ) && !dqm;
  endsequence
  sequence mask_issue;
    live && dqm;
  endsequence

  read_drive_a: assert property (read_issue ##1 cke |=> !data_lines_oe_n)
    else $error("read data not driven two edges after read");
  mask_float_a: assert property (mask_issue ##1 cke |=> data_lines_oe_n)
    else $error("byte mask did not float outputs two edges later");
  cs_ignore_a: assert property (live && cs_n && !st_q.bact |=> $stable(st_q.open) && $stable(st_q.row))
    else $error("command taken with decoder disabled");
  idle_down_a: assert property ((st_q.pwr == PWR_RUN) && !cke && !st_q.bact && (st_q.open == '0)
    |=> st_q.pwr inside {PWR_PD_PRE, PWR_SELF})
    else $error("idle gate low did not enter low power");
  act_down_a: assert property ((st_q.pwr == PWR_RUN) && !cke && !st_q.bact && (st_q.open != '0)
    |=> st_q.pwr == PWR_PD_ACT)
    else $error("open row gate low did not enter active power-down");
  burst_hold_a: assert property (!cke && st_q.bact && (st_q.pwr inside {PWR_RUN, PWR_SUSPEND})
    |=> (st_q.pwr == PWR_SUSPEND) && $stable(st_q.bcnt) && $stable(st_q.mem))
    else $error("burst moved while clock held");
  rcv_off_a: assert property (st_q.pwr inside {PWR_PD_PRE, PWR_PD_ACT, PWR_SELF}
    |=> $stable(st_q.mem) && $stable(st_q.open))
    else $error("inputs acted on in low power");
  pre_all_a: assert property (live && (cmd == SDPC_PRECH) && address_lines[PRE_SCOPE_BIT]
    |=> st_q.open == '0)
    else $error("precharge all left a bank open");
  open_row_a: assert property (live && (cmd == SDPC_ACTIVE)
    |=> st_q.open[$past(bank_select)] && (st_q.row[$past(bank_select)] == $past(address_lines)))
    else $error("activate did not open the row");
  burst_run_a: assert property (live && st_q.bact && cs_n && !last
    |=> st_q.bact && (st_q.bcnt == COL_W'($past(st_q.bcnt) + 1'b1)))
    else $error("burst stalled under deselect");
  wr_mask_a: assert property (live && (cmd == SDPC_WRITE) && dqm |=> $stable(st_q.mem))
    else $error("masked write changed storage");
  cfg_load_a: assert property (live && (cmd == SDPC_LOADCFG)
    |=> st_q.cfg == $past({bank_select, address_lines}))
    else $error("configuration load lost");
  // Exit is taken on the first edge that sees the gate high again
  pd_exit_a: assert property ((st_q.pwr inside {PWR_PD_PRE, PWR_PD_ACT, PWR_SELF}) && cke
    |=> st_q.pwr == PWR_RUN)
    else $error("gate high did not leave low power");
  // A held clock must also freeze what stands on the data pins
  hold_pins_a: assert property (!cke && st_q.bact && (st_q.pwr inside {PWR_RUN, PWR_SUSPEND})
    |=> $stable(data_lines_oe_n) && $stable(data_lines_o))
    else $error("data pins moved while clock held");
  // An activate to the same bank at that edge would legally reopen it
  ap_close_a: assert property (live && go && last && ap_m && (cmd != SDPC_ACTIVE)
    |=> !st_q.open[$past(bank_m)])
    else $error("auto precharge left the bank open");
  act_code_a: assert property (live && !cs_n && ({ras_n, cas_n, we_n} == STB_ACTIVE)
    |-> cmd == SDPC_ACTIVE)
    else $error("activate strobes not decoded");
endmodule // sdpc_pin_cmd

// ==== rtl/sdpc_pkg.sv ====
// Constants and types shared by the synchronous DRAM pin command block.
// Assumes one clock (pclk); all pin inputs arrive synchronous to it.
// What this block does
// - All inputs except presetn are captured only at the rising clock edge.
// - Every running edge clocks the output registers and, during a burst, advances the burst counter.
// - Clock gate low with all banks idle enters precharge power-down or self refresh.
// - Clock gate low with any row open and no burst running enters active power-down.
// - Clock gate low during a burst freezes it until the gate returns high.
// - Power-down and self refresh ignore every pin input except the clock gate.
// - Decoder enable low accepts a command; high ignores every command.
// - With decoder enable high, running bursts continue and the byte mask still works.
// - Decoder enable and the three strobes together encode the command.
// - Byte mask high during a read floats the data outputs two clocks later.
// - Bank select picks the bank for activate, read, write and precharge.
// - Activate opens the row given on address lines 0 to 12.
// - Read or write takes the starting column from address lines 0 to 9.
// - Address line 10 with read or write requests auto precharge at burst end.
// - Precharge with address line 10 high closes all banks, else the selected bank.
// - The data bus is eight bits wide in this build.
// - An access opens a row first, then reads or writes a column.
// - Bursts cover a configured length in a configured order from the start column.
package sdpc_pkg;
  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int ADDR_W    = 13;
  localparam int BANK_W    = 2;
  localparam int BANKS     = 4;
  localparam int DATA_W    = 8;
  localparam int COL_W     = 10;
  localparam int MEM_IDX_W = 3;
  localparam int MEM_DEPTH = BANKS * (2 ** MEM_IDX_W);
  localparam int PADDR_W   = 8;
  localparam int PDATA_W   = 32;
  localparam int CFG_W     = BANK_W + ADDR_W;
  localparam int PRE_SCOPE_BIT = 10;

  // ---------------------------------------------------------------
  // Strobe codes {row, column, write}, all active low
  // ---------------------------------------------------------------
  localparam logic [2:0] STB_LOADCFG = 3'h0;
  localparam logic [2:0] STB_REFRESH = 3'h1;
  localparam logic [2:0] STB_PRECH   = 3'h2;
  localparam logic [2:0] STB_ACTIVE  = 3'h3;
  localparam logic [2:0] STB_WRITE   = 3'h4;
  localparam logic [2:0] STB_READ    = 3'h5;
  localparam logic [2:0] STB_TERM    = 3'h6;
  localparam logic [2:0] STB_NOP     = 3'h7;

  typedef enum logic [3:0] {
    SDPC_INHIBIT, SDPC_NOP, SDPC_ACTIVE, SDPC_READ, SDPC_WRITE,
    SDPC_TERM, SDPC_PRECH, SDPC_REFRESH, SDPC_LOADCFG
  } sdpc_cmd_t;

  typedef enum logic [2:0] {
    PWR_RUN, PWR_SUSPEND, PWR_PD_PRE, PWR_PD_ACT, PWR_SELF
  } sdpc_pwr_t;

  // ---------------------------------------------------------------
  // Burst length codes and configuration fields
  // ---------------------------------------------------------------
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam int CFG_BL_LSB    = 0;
  localparam int CFG_BL_W      = 3;
  localparam int CFG_ORDER_BIT = 3;
  localparam logic [CFG_W-1:0] CFG_RST = 15'h0000;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [PADDR_W-1:0] REG_CFG  = 8'h00;
  localparam logic [PADDR_W-1:0] REG_STAT = 8'h04;
  localparam int STAT_PWR_LSB  = 0;
  localparam int STAT_OPEN_LSB = 4;
  localparam int STAT_RD_BIT   = 8;
  localparam int STAT_WR_BIT   = 9;
endpackage

// ==== tb/sdpc_ctrl_model.sv ====
// Controller-side model driving the DRAM clock gate, command, mask and data pins.
// Assumes the bench calls issue() from one process, once per command slot.
module sdpc_ctrl_model
  import sdpc_pkg::*;
(
  // Clock
  input  wire logic              pclk,
  // Pins towards the device
  output logic                   cke,
  output logic                   cs_n,
  output logic                   ras_n,
  output logic                   cas_n,
  output logic                   we_n,
  output logic                   dqm,
  output logic      [BANK_W-1:0] bank_select,
  output logic      [ADDR_W-1:0] address_lines,
  output logic      [DATA_W-1:0] data_lines_i
);
  timeunit 1ns;
  timeprecision 100ps;

  logic              wr_en_q;
  logic [DATA_W-1:0] wr_d_q;
  logic [DATA_W-1:0] idle_q = 8'h5a;

  // Released data lines toggle each cycle so a stale beat is never taken as good
  always @(posedge pclk) begin
    idle_q <= ~idle_q;
  end
  assign data_lines_i = wr_en_q ? wr_d_q : idle_q;

  // Idle pins: deselected, no operation, gate high
  initial begin
    wr_en_q       = 1'b0;
    wr_d_q        = 8'h00;
    cke           = 1'b1;
    cs_n          = 1'b1;
    {ras_n, cas_n, we_n} = STB_NOP;
    dqm           = 1'b0;
    bank_select   = 2'h0;
    address_lines = 13'h0000;
  end

  // One slot: pins change just after an edge and hold until the next one
  task automatic issue(input logic k, input logic sel_n, input logic [2:0] stb, input logic [BANK_W-1:0] ba,
                       input logic [ADDR_W-1:0] a, input logic m, input logic w, input logic [DATA_W-1:0] d);
    @(posedge pclk);
    cke                  <= k;
    cs_n                 <= sel_n;
    {ras_n, cas_n, we_n} <= stb;
    bank_select          <= ba;
    address_lines        <= a;
    dqm                  <= m;
    wr_en_q              <= w;
    wr_d_q               <= d;
  endtask
endmodule // sdpc_ctrl_model

// ==== tb/sdpc_pin_cmd_tb.sv ====
// Self-checking bench for the DRAM pin command block.
// Assumes APB register access and a controller model on the pins.
module sdpc_pin_cmd_tb
  import sdpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic               pclk;
  logic               presetn;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [PADDR_W-1:0] paddr;
  logic [PDATA_W-1:0] pwdata;
  logic [PDATA_W-1:0] prdata;
  logic               pready;
  logic               pslverr;
  logic               cke;
  logic               cs_n;
  logic               ras_n;
  logic               cas_n;
  logic               we_n;
  logic               dqm;
  logic [BANK_W-1:0]  bank_select;
  logic [ADDR_W-1:0]  address_lines;
  logic [DATA_W-1:0]  data_lines_i;
  logic [DATA_W-1:0]  data_lines_o;
  logic               data_lines_oe_n;
  logic [PDATA_W-1:0] rd;
  logic               er;
  int                 err_total;
  int                 n_checks;
  int                 cycles;
  logic [7:0]         wdat [8] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88};

  sdpc_pin_cmd sdpc_pin_cmd_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .dqm(dqm),
    .bank_select(bank_select), .address_lines(address_lines), .data_lines_i(data_lines_i),
    .data_lines_o(data_lines_o), .data_lines_oe_n(data_lines_oe_n));

  sdpc_ctrl_model ctrl_inst (.pclk(pclk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .dqm(dqm), .bank_select(bank_select), .address_lines(address_lines),
    .data_lines_i(data_lines_i));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // APB transfer; the request holds until pready is seen high at an edge
  task automatic apb(input logic w, input logic [PADDR_W-1:0] a, input logic [PDATA_W-1:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic stat(input logic [31:0] exp);
    apb(1'b0, REG_STAT, 32'h0);
    chk(rd, exp);
  endtask

  // Command followed by one no-operation slot so nothing repeats
  task automatic cmd(input logic sel_n, input logic [2:0] stb, input logic [1:0] ba, input logic [12:0] a);
    ctrl_inst.issue(1'b1, sel_n, stb, ba, a, 1'b0, 1'b0, 8'h00);
    ctrl_inst.issue(1'b1, 1'b0, STB_NOP, 2'h0, 13'h0000, 1'b0, 1'b0, 8'h00);
  endtask

  // Deselected slot during a read burst, then look at the settled beat
  task automatic rbeat(input logic m, input logic eo, input logic [7:0] ed);
    ctrl_inst.issue(1'b1, 1'b1, STB_NOP, 2'h0, 13'h0000, m, 1'b0, 8'h00);
    #1;
    chk(data_lines_oe_n, eo);
    if (!eo) chk(data_lines_o, ed);
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Hang guard: the sequence needs little more than a hundred cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      report_and_stop();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk(data_lines_oe_n, 1'b1);
    stat(32'h0);
    apb(1'b0, REG_CFG, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, REG_CFG, 32'hffff_0002);
    apb(1'b0, REG_CFG, 32'h0);
    chk(rd, 32'h0000_0002);
    apb(1'b0, 8'h08, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    // Open bank 1, then two back-to-back four-beat writes from column 0
    cmd(1'b0, STB_ACTIVE, 2'h1, 13'h1abc);
    stat(32'h0000_0020);
    for (int i = 0; i < 8; i++) begin
      ctrl_inst.issue(1'b1, 1'b0, (i % 4 == 0) ? STB_WRITE : STB_NOP, 2'h1, 13'h0000, i == 5, 1'b1, wdat[i]);
    end
    // Read with auto precharge, deselected meanwhile, mask on the third beat
    cmd(1'b0, STB_READ, 2'h1, 13'h0400);
    rbeat(1'b1, 1'b0, 8'h55);
    rbeat(1'b0, 1'b0, 8'h22);
    rbeat(1'b0, 1'b1, 8'h00);
    rbeat(1'b0, 1'b0, 8'h88);
    rbeat(1'b0, 1'b1, 8'h00);
    stat(32'h0);
    // Deselected command is dropped; two real ones open banks 2 and 3
    cmd(1'b1, STB_ACTIVE, 2'h0, 13'h0000);
    cmd(1'b0, STB_ACTIVE, 2'h2, 13'h0000);
    cmd(1'b0, STB_ACTIVE, 2'h3, 13'h0000);
    stat(32'h0000_00c0);
    cmd(1'b0, STB_PRECH, 2'h2, 13'h0000);
    stat(32'h0000_0080);
    // Gate low with a row open, then wake with a command that must be ignored
    ctrl_inst.issue(1'b0, 1'b0, STB_NOP, 2'h0, 13'h0000, 1'b0, 1'b0, 8'h00);
    stat(32'h0000_0083);
    ctrl_inst.issue(1'b1, 1'b0, STB_ACTIVE, 2'h0, 13'h0000, 1'b0, 1'b0, 8'h00);
    cmd(1'b0, STB_NOP, 2'h0, 13'h0000);
    stat(32'h0000_0080);
    cmd(1'b0, STB_PRECH, 2'h0, 13'h0400);
    stat(32'h0);
    // All idle: precharge power-down, then self refresh
    ctrl_inst.issue(1'b0, 1'b0, STB_NOP, 2'h0, 13'h0000, 1'b0, 1'b0, 8'h00);
    stat(32'h0000_0002);
    ctrl_inst.issue(1'b1, 1'b0, STB_NOP, 2'h0, 13'h0000, 1'b0, 1'b0, 8'h00);
    ctrl_inst.issue(1'b0, 1'b0, STB_REFRESH, 2'h0, 13'h0000, 1'b0, 1'b0, 8'h00);
    stat(32'h0000_0004);
    ctrl_inst.issue(1'b1, 1'b1, STB_NOP, 2'h0, 13'h0000, 1'b0, 1'b0, 8'h00);
    cmd(1'b0, STB_NOP, 2'h0, 13'h0000);
    stat(32'h0);
    // Interleaved four-beat write from column 1, held once by the gate, rest deselected
    apb(1'b1, REG_CFG, 32'h0000_000a);
    cmd(1'b0, STB_ACTIVE, 2'h2, 13'h0000);
    ctrl_inst.issue(1'b1, 1'b0, STB_WRITE, 2'h2, 13'h0001, 1'b0, 1'b1, 8'ha1);
    ctrl_inst.issue(1'b0, 1'b0, STB_NOP, 2'h2, 13'h0000, 1'b0, 1'b1, 8'hee);
    stat(32'h0000_0241);
    ctrl_inst.issue(1'b1, 1'b1, STB_NOP, 2'h2, 13'h0000, 1'b0, 1'b1, 8'hb2);
    ctrl_inst.issue(1'b1, 1'b1, STB_NOP, 2'h2, 13'h0000, 1'b0, 1'b1, 8'hc3);
    ctrl_inst.issue(1'b1, 1'b1, STB_NOP, 2'h2, 13'h0000, 1'b0, 1'b1, 8'hd4);
    // Read from column 2, burst stop after the second beat lets one more out
    cmd(1'b0, STB_READ, 2'h2, 13'h0002);
    ctrl_inst.issue(1'b1, 1'b0, STB_TERM, 2'h0, 13'h0000, 1'b0, 1'b0, 8'h00);
    #1;
    chk(data_lines_oe_n, 1'b0);
    chk(data_lines_o, 32'h0000_00d4);
    rbeat(1'b0, 1'b0, 8'hc3);
    rbeat(1'b0, 1'b0, 8'hb2);
    rbeat(1'b0, 1'b1, 8'h00);
    // Configuration load from the pins
    cmd(1'b0, STB_LOADCFG, 2'h1, 13'h0003);
    apb(1'b0, REG_CFG, 32'h0);
    chk(rd, 32'h0000_2003);
    report_and_stop();
  end
endmodule // sdpc_pin_cmd_tb
